// ---- logic/gpev_top.sv ----
/*
 * gpev_top: eight open-drain general-purpose pins with direction,
 * polarity, status and alert mask, plus two latched event outputs.
 * Assumes pins arrive asynchronously; internal event inputs and the
 * register port are on MCLK.
 */
`timescale 1ns/100ps

// How it works
// RULE1: eight open-drain pins; pins seven, eight plain
// RULE2: pins five, six event outputs; one-four sources
// RULE3: each pin: three config, status, mask bits; code keeps two config bits per pin (direction, polarity)
// RULE4: direction one is output, zero input
// RULE5: polarity one active high, zero low
// RULE6: input status read-only, shows asserted level
// RULE7: output status writable, asserts pin
// RULE8: mask bit keeps status off alert
// RULE9: output pins masked from alert automatically
// RULE10: two event masks, one per output
// RULE11: event output level follows pin polarity
// RULE12: mask bits 7-5 gate voltage, thermal, fan
// RULE13: mask bits 0-3 gate pins one-four, ORed
// RULE14: source pins set or reset outputs autonomously
// RULE15: latched output holds until cleared or reset
// RULE16: pin inputs synchronised before use
module gpev_top
    import gpev_pkg::*;
(
    // clock and reset
    input  wire logic       MCLK,
    input  wire logic       RST,
    // register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // internal events
    input  wire logic       VOLT_EVT,
    input  wire logic       THERMAL_LIMIT_EVENT_EVT,
    input  wire logic       FAN_EVT,
    // open-drain pins
    input  wire logic [7:0] GP_IN,
    output logic      [7:0] GP_OUT,
    output logic      [7:0] GP_OE,
    // alert
    output logic            ALERT_ACT
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] cfg_lo;
        logic [7:0] cfg_hi;
        logic [7:0] alert_mask;
        logic [7:0] evt1_mask;
        logic [7:0] evt2_mask;
        logic [7:0] ctrl;
        logic [7:0] out_val;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] pin_lvl;
        logic [1:0] latched;
        logic [7:0] drive;
        logic       alert;
        logic [7:0] rdata;
    } gpev_state_t;

    localparam gpev_state_t ST_RESET = '{
        cfg_lo:     RST_CFG,
        cfg_hi:     RST_CFG,
        alert_mask: RST_MASK,
        evt1_mask:  RST_EVT_MASK,
        evt2_mask:  RST_EVT_MASK,
        ctrl:       RST_CTRL,
        out_val:    RST_ZERO,
        // synchroniser starts at the idle pin level, so no false alert
        sync1:      RST_PIN_IDLE,
        sync2:      RST_PIN_IDLE,
        sync3:      RST_PIN_IDLE,
        pin_lvl:    RST_PIN_IDLE,
        latched:    2'h0,
        drive:      RST_ZERO,
        alert:      1'b0,
        rdata:      RST_ZERO
    };

    gpev_state_t state_r;
    gpev_state_t state_nxt;

    // ==========================================================
    // event source decode, shared by both outputs
    function automatic logic evt_source(
        input logic [7:0] emask,
        input logic [3:0] src_pins,
        input logic       volt,
        input logic       thermal_limit_event,
        input logic       fan
    );
        logic hit;
        hit = |(src_pins & ~emask[EMSK_PIN_LSB +: 4]);
        hit = hit | (volt & ~emask[EMSK_VOLT_BIT]);
        hit = hit | (thermal_limit_event & ~emask[EMSK_THERMAL_LIMIT_EVENT_BIT]);
        hit = hit | (fan & ~emask[EMSK_FAN_BIT]);
        return hit;
    endfunction : evt_source

    // ==========================================================
    // decoded views of the registers
    logic [7:0] dir;
    logic [7:0] pol;
    logic [7:0] dir_eff;
    logic [7:0] in_asserted;
    logic [7:0] status;
    logic [1:0] evt_src;
    logic [1:0] evt_lvl;
    logic [1:0] latch_en;
    logic [1:0] latch_clr;
    logic       evt_en;
    logic       wr_ctrl;

    // RULE3: per-pin direction and polarity split over two groups
    assign dir = {state_r.cfg_hi[CFG_DIR_LSB +: 4], state_r.cfg_lo[CFG_DIR_LSB +: 4]};
    assign pol = {state_r.cfg_hi[CFG_POL_LSB +: 4], state_r.cfg_lo[CFG_POL_LSB +: 4]};

    assign evt_en   = state_r.ctrl[CTL_EVT_EN_BIT];
    assign latch_en = {state_r.ctrl[CTL_LATCH2_BIT], state_r.ctrl[CTL_LATCH1_BIT]};
    assign wr_ctrl  = REG_WR && (REG_ADDR == OFS_EVT_OUT_CTRL);
    assign latch_clr = wr_ctrl ? {REG_WDATA[CTL_CLEAR2_BIT], REG_WDATA[CTL_CLEAR1_BIT]} : 2'h0;

    // RULE5: asserted means the pin sits at its polarity level
    assign in_asserted = ~(state_r.pin_lvl ^ pol);

    // RULE12: internal events gated by bits 7-5
    // RULE13: unmasked source pins ORed together
    assign evt_src[0] = evt_source(state_r.evt1_mask, status[3:0], VOLT_EVT, THERMAL_LIMIT_EVENT_EVT, FAN_EVT);
    assign evt_src[1] = evt_source(state_r.evt2_mask, status[3:0], VOLT_EVT, THERMAL_LIMIT_EVENT_EVT, FAN_EVT);

    // RULE15: latched level holds once set
    assign evt_lvl = (state_r.latched & latch_en) | evt_src;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            if (gi == EVT_PIN1 || gi == EVT_PIN2)
            begin : g_evt
                // RULE2: pins five and six become event outputs when enabled
                assign dir_eff[gi] = dir[gi] | evt_en;
                assign status[gi]  = evt_en ? evt_lvl[gi - EVT_PIN1] :
                                     (dir[gi] ? state_r.out_val[gi] : in_asserted[gi]);
            end
            else
            begin : g_plain
                // RULE1: remaining pins are plain logic inputs or outputs
                assign dir_eff[gi] = dir[gi];
                // RULE6: input status follows synchronised pin
                // RULE7: output status is the written value
                assign status[gi]  = dir[gi] ? state_r.out_val[gi] : in_asserted[gi];
            end
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb
    begin
        state_nxt = state_r;

        // RULE16: three-stage synchroniser, change taken when stages agree
        state_nxt.sync1 = GP_IN;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.sync3 = state_r.sync2;
        for (int i = 0; i < 8; i++)
        begin
            if (state_r.sync2[i] == state_r.sync3[i])
            begin
                state_nxt.pin_lvl[i] = state_r.sync3[i];
            end
        end

        if (REG_WR)
        begin
            case (REG_ADDR)
                OFS_PIN_CFG_LOW:   state_nxt.cfg_lo     = REG_WDATA;
                OFS_PIN_CFG_HIGH:  state_nxt.cfg_hi     = REG_WDATA;
                OFS_PIN_ALERT_MSK: state_nxt.alert_mask = REG_WDATA;
                // RULE10: one event mask per output
                OFS_EVT_OUT1_MSK:  state_nxt.evt1_mask  = REG_WDATA;
                OFS_EVT_OUT2_MSK:  state_nxt.evt2_mask  = REG_WDATA;
                OFS_EVT_OUT_CTRL:  state_nxt.ctrl       = REG_WDATA & CTL_WR_MASK;
                // RULE7: only output pins take the written value
                OFS_PIN_STATE:     state_nxt.out_val    = (REG_WDATA & dir) | (state_r.out_val & ~dir);
                default:           state_nxt.out_val    = state_r.out_val;
            endcase
        end

        // RULE15: clear by register write; a new event wins over the clear
        // RULE14: source pins set the output with no software help
        state_nxt.latched = (state_r.latched & ~latch_clr) | (evt_src & latch_en);

        // RULE4: only output pins are ever driven
        // RULE11: event outputs drive through their pin polarity
        // pin level = polarity when asserted; low level means pull down
        state_nxt.drive = dir_eff & ~(~(status ^ pol));

        // RULE8: mask bit removes a pin from alert
        // RULE9: output pins never reach alert
        state_nxt.alert = |(status & ~state_r.alert_mask & ~dir_eff);

        state_nxt.rdata = RST_ZERO;
        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_PIN_CFG_LOW:   state_nxt.rdata = state_r.cfg_lo;
                OFS_PIN_CFG_HIGH:  state_nxt.rdata = state_r.cfg_hi;
                OFS_PIN_ALERT_MSK: state_nxt.rdata = state_r.alert_mask;
                OFS_EVT_OUT1_MSK:  state_nxt.rdata = state_r.evt1_mask;
                OFS_EVT_OUT2_MSK:  state_nxt.rdata = state_r.evt2_mask;
                OFS_EVT_OUT_CTRL:  state_nxt.rdata = state_r.ctrl;
                // RULE6: reads show live pin state
                OFS_PIN_STATE:     state_nxt.rdata = status;
                default:           state_nxt.rdata = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= ST_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign GP_OUT    = RST_ZERO;
    assign GP_OE     = state_r.drive;
    assign ALERT_ACT = state_r.alert;
    assign REG_RDATA = state_r.rdata;

    // ==========================================================
    // checks
    sequence s_pin0_low_held;
        (!dir[0] && pol[0] && !GP_IN[0]) [*5];
    endsequence

    sequence s_latch_set1;
        latch_en[0] && evt_src[0];
    endsequence

    a_in_status_follow: assert property (  // RULE6
        @(posedge MCLK) disable iff (RST)
        s_pin0_low_held |-> !status[0])
        else $error("input status does not follow pin");

    a_sync_no_early: assert property (  // RULE16
        @(posedge MCLK) disable iff (RST)
        ($rose(GP_IN[1]) && !dir[1] && $stable(pol[1])) |=> $stable(state_r.pin_lvl[1]))
        else $error("pin level taken without synchroniser");

    a_out_drive_pin: assert property (  // RULE7
        @(posedge MCLK) disable iff (RST)
        (dir[0] && !pol[0] && state_r.out_val[0]) |=> GP_OE[0])
        else $error("asserted active-low output not pulled down");

    a_input_released: assert property (  // RULE4
        @(posedge MCLK) disable iff (RST)
        (!dir[7] && !dir[6]) |=> (GP_OE[7:6] == 2'h0))
        else $error("input pin is driven");

    a_mask_blocks_alert: assert property (  // RULE8
        @(posedge MCLK) disable iff (RST)
        (state_r.alert_mask == 8'hFF) |=> !ALERT_ACT)
        else $error("masked pin raised alert");

    a_out_auto_mask: assert property (  // RULE9
        @(posedge MCLK) disable iff (RST)
        (dir == 8'hFF) |=> !ALERT_ACT)
        else $error("output pin raised alert");

    a_thermal_limit_event_drives_evt: assert property (  // RULE12
        @(posedge MCLK) disable iff (RST)
        (evt_en && !state_r.evt1_mask[EMSK_THERMAL_LIMIT_EVENT_BIT] && THERMAL_LIMIT_EVENT_EVT) |-> status[EVT_PIN1])
        else $error("thermal event did not drive output");

    a_pin_mask_ignores: assert property (  // RULE13
        @(posedge MCLK) disable iff (RST)
        (state_r.evt2_mask == 8'hFF && !latch_en[1]) |-> !evt_lvl[1])
        else $error("fully masked output asserted");

    a_latch_holds: assert property (  // RULE15
        @(posedge MCLK) disable iff (RST)
        (s_latch_set1 ##1 (latch_en[0] && !latch_clr[0]) [*3]) |-> evt_lvl[0])
        else $error("latched output dropped");

    a_evt_polarity: assert property (  // RULE11
        @(posedge MCLK) disable iff (RST)
        (evt_en && evt_lvl[1] && pol[EVT_PIN2]) |=> !GP_OE[EVT_PIN2])
        else $error("active-high event output pulled low");

    a_plain_pins: assert property (  // RULE1
        @(posedge MCLK) disable iff (RST)
        (dir[7] && pol[7]) |=> (GP_OE[7] == !$past(state_r.out_val[7])))
        else $error("plain pin drive wrong");

    a_status_read: assert property (  // RULE6
        @(posedge MCLK) disable iff (RST)
        (REG_RD && REG_ADDR == OFS_PIN_STATE) |=> (REG_RDATA == $past(status)))
        else $error("status read mismatch");

    sequence s_latch_clear1;
        latch_clr[0] && !(evt_src[0] && latch_en[0]);
    endsequence

    a_latch_clears: assert property (  // RULE15
        @(posedge MCLK) disable iff (RST)
        s_latch_clear1 |=> !state_r.latched[0])
        else $error("latch not cleared");

    a_alert_raised: assert property (  // RULE8
        @(posedge MCLK) disable iff (RST)
        (|(status & ~state_r.alert_mask & ~dir_eff)) |=> ALERT_ACT)
        else $error("unmasked input did not raise alert");

    a_evt_off_plain: assert property (  // RULE2
        @(posedge MCLK) disable iff (RST)
        (!evt_en && !dir[EVT_PIN1]) |=> !GP_OE[EVT_PIN1])
        else $error("event pin driven while disabled");

    a_pin_sets_evt: assert property (  // RULE14
        @(posedge MCLK) disable iff (RST)
        (evt_en && !state_r.evt1_mask[EMSK_PIN_LSB] && status[0]) |-> status[EVT_PIN1])
        else $error("source pin did not drive event output");

    a_evt_mask_read: assert property (  // RULE10
        @(posedge MCLK) disable iff (RST)
        (REG_RD && REG_ADDR == OFS_EVT_OUT2_MSK) |=> (REG_RDATA == $past(state_r.evt2_mask)))
        else $error("event mask read mismatch");

endmodule : gpev_top

// ---- logic/gpev_pkg.sv ----
/*
 * gpev_pkg: register offsets, field positions and reset values of the
 * general-purpose pin and event-output block.
 * Assumes one 8-bit register port and a single 25 MHz clock.
 */
package gpev_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_PIN_CFG_LOW   = 8'h09;
    localparam logic [7:0] OFS_PIN_CFG_HIGH  = 8'h0A;
    localparam logic [7:0] OFS_PIN_ALERT_MSK = 8'h36;
    localparam logic [7:0] OFS_EVT_OUT1_MSK  = 8'h37;
    localparam logic [7:0] OFS_EVT_OUT2_MSK  = 8'h38;
    localparam logic [7:0] OFS_EVT_OUT_CTRL  = 8'h39;
    localparam logic [7:0] OFS_PIN_STATE     = 8'hBF;

    // ==========================================================
    // field layout of a config group: direction low nibble, polarity high
    localparam int CFG_DIR_LSB = 0;
    localparam int CFG_POL_LSB = 4;

    // event mask fields
    localparam int EMSK_VOLT_BIT  = 7;
    localparam int EMSK_THERMAL_LIMIT_EVENT_BIT = 6;
    localparam int EMSK_FAN_BIT   = 5;
    localparam int EMSK_PIN_LSB   = 0;

    // event output control fields
    localparam int CTL_EVT_EN_BIT  = 0;
    localparam int CTL_LATCH1_BIT  = 1;
    localparam int CTL_LATCH2_BIT  = 2;
    localparam int CTL_CLEAR1_BIT  = 3;
    localparam int CTL_CLEAR2_BIT  = 4;
    localparam logic [7:0] CTL_WR_MASK = 8'h07;

    // pins acting as event outputs
    localparam int EVT_PIN1 = 4;
    localparam int EVT_PIN2 = 5;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_CFG      = 8'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_EVT_MASK = 8'hFF;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    // pins idle high on their pull-ups
    localparam logic [7:0] RST_PIN_IDLE = 8'hFF;

endpackage : gpev_pkg

// ---- tb/gpev_pins_model.sv ----
/*
 * gpev_pins_model: board side of the eight open-drain pins.
 * Assumes a pull-up on every pin and an external part that may pull low.
 */
`timescale 1ns/100ps
module gpev_pins_model
(
    // block side
    input  wire logic [7:0] gp_oe,
    input  wire logic [7:0] gp_out,
    // external parts pulling low
    input  wire logic [7:0] ext_low,
    // wire levels
    output logic      [7:0] gp_in
);
    // ==========================================================
    // wired-and with pull-up
    // open drain, pulled up
    assign gp_in = ((gp_oe & gp_out) | ~gp_oe) & ~ext_low;
endmodule : gpev_pins_model

// ---- tb/gpev_top_tb.sv ----
/*
 * gpev_top_tb: self-checking bench with a queue-free reference model.
 * Assumes gpev_top, gpev_pkg and gpev_pins_model are compiled before it.
 */
`timescale 1ns/100ps
module gpev_top_tb
    import gpev_pkg::*;
;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic        VOLT_EVT = 1'b0;
    logic        THERMAL_LIMIT_EVENT_EVT = 1'b0;
    logic        FAN_EVT = 1'b0;
    logic        ALERT_ACT;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [7:0]  REG_WDATA = 8'h00;
    logic [7:0]  ext_low = 8'h00;
    logic [7:0]  REG_RDATA, GP_IN, GP_OUT, GP_OE;
    logic [7:0]  cfg_l, cfg_h, amask, m1, m2, ctl, st_w;
    logic [1:0]  lat;
    logic [31:0] seed = 32'h7F63;
    logic [7:0]  offs [8] = '{OFS_PIN_CFG_LOW, OFS_PIN_CFG_HIGH, OFS_PIN_ALERT_MSK,
                     OFS_EVT_OUT1_MSK, OFS_EVT_OUT2_MSK, OFS_EVT_OUT_CTRL, OFS_PIN_STATE, 8'h55};
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #20 MCLK = ~MCLK;

    gpev_top gpev_top_inst (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .VOLT_EVT(VOLT_EVT),
        .THERMAL_LIMIT_EVENT_EVT(THERMAL_LIMIT_EVENT_EVT), .FAN_EVT(FAN_EVT), .GP_IN(GP_IN), .GP_OUT(GP_OUT), .GP_OE(GP_OE),
        .ALERT_ACT(ALERT_ACT));
    gpev_pins_model gpev_pins_model_inst (.gp_oe(GP_OE), .gp_out(GP_OUT), .ext_low(ext_low),
        .gp_in(GP_IN));

    // ==========================================================
    // reference model
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs

    function automatic logic [7:0] base_st();
        logic [7:0] d;
        d = {cfg_h[3:0], cfg_l[3:0]};
        return (d & st_w) | (~d & (ext_low ^ {cfg_h[7:4], cfg_l[7:4]}));
    endfunction : base_st

    function automatic logic evo(input int k);
        logic [7:0] m;
        logic [7:0] s;
        m = k ? m2 : m1;
        s = base_st();
        return |(~m[3:0] & s[3:0]) | (~m[7] & VOLT_EVT) | (~m[6] & THERMAL_LIMIT_EVENT_EVT)
            | (~m[5] & FAN_EVT) | (ctl[k + 1] & lat[k]);
    endfunction : evo

    function automatic logic [7:0] exp_st();
        logic [7:0] s;
        s = base_st();
        if (ctl[CTL_EVT_EN_BIT])
            s[EVT_PIN2:EVT_PIN1] = {evo(1), evo(0)};
        return s;
    endfunction : exp_st

    function automatic logic [7:0] dir_e();
        return {cfg_h[3:0], cfg_l[3:0]} | (ctl[CTL_EVT_EN_BIT] ? 8'h30 : 8'h00);
    endfunction : dir_e

    function automatic logic [7:0] reg_exp(input logic [7:0] a);
        case (a)
            OFS_PIN_CFG_LOW:   return cfg_l;
            OFS_PIN_CFG_HIGH:  return cfg_h;
            OFS_PIN_ALERT_MSK: return amask;
            OFS_EVT_OUT1_MSK:  return m1;
            OFS_EVT_OUT2_MSK:  return m2;
            OFS_EVT_OUT_CTRL:  return ctl;
            OFS_PIN_STATE:     return exp_st();
            default:           return 8'h00;
        endcase
    endfunction : reg_exp

    // ==========================================================
    // bus and check tasks
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        case (a)
            OFS_PIN_CFG_LOW:   cfg_l = d;
            OFS_PIN_CFG_HIGH:  cfg_h = d;
            OFS_PIN_ALERT_MSK: amask = d;
            OFS_EVT_OUT1_MSK:  m1 = d;
            OFS_EVT_OUT2_MSK:  m2 = d;
            OFS_EVT_OUT_CTRL:  ctl = d & CTL_WR_MASK;
            OFS_PIN_STATE:     st_w = (st_w & ~{cfg_h[3:0], cfg_l[3:0]}) | (d & {cfg_h[3:0], cfg_l[3:0]});
            default:           ;
        endcase
        if (a == OFS_EVT_OUT_CTRL)
            lat = lat & ~d[4:3];
    endtask : wr

    task automatic rd(input logic [7:0] a, input string what);
        logic [7:0] e;
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        e = reg_exp(a);
        #1;
        cmp(what, e, REG_RDATA);
    endtask : rd

    task automatic settle_check();
        repeat (6) @(posedge MCLK);
        #1;
        for (int k = 0; k < 2; k++)
            if (ctl[k + 1] && evo(k))
                lat[k] = 1'b1;
        cmp("GP_OE", dir_e() & (exp_st() ^ {cfg_h[7:4], cfg_l[7:4]}), GP_OE);
        cmp("GP_OUT", 8'h00, GP_OUT);
        cmp("ALERT_ACT", {7'h00, |(exp_st() & ~amask & ~dir_e())}, {7'h00, ALERT_ACT});
        rd(OFS_PIN_STATE, "status");
    endtask : settle_check

    task automatic reset_dut();
        @(posedge MCLK);
        RST       <= 1'b1;
        ext_low   <= 8'h00;
        VOLT_EVT  <= 1'b0;
        THERMAL_LIMIT_EVENT_EVT <= 1'b0;
        FAN_EVT   <= 1'b0;
        {cfg_l, cfg_h, amask, ctl, st_w, lat} = '0;
        m1 = RST_EVT_MASK;
        m2 = RST_EVT_MASK;
        repeat (4) @(posedge MCLK);
        RST <= 1'b0;
        #1;
        cmp("GP_OE", 8'h00, GP_OE);
        repeat (2) @(posedge MCLK);
        #1;
        cmp("ALERT_ACT", 8'h00, {7'h00, ALERT_ACT});
        repeat (4) @(posedge MCLK);
        wr(8'h55, 8'hA5);
        foreach (offs[i])
            rd(offs[i], "register");
        $display("test reset done");
    endtask : reset_dut

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] r;
        reset_dut();
        repeat (12)
        begin
            wr(OFS_PIN_CFG_LOW, xs());
            wr(OFS_PIN_CFG_HIGH, xs());
            wr(OFS_PIN_ALERT_MSK, xs());
            wr(OFS_PIN_STATE, xs());
            @(posedge MCLK);
            ext_low <= xs();
            settle_check();
        end
        wr(OFS_PIN_ALERT_MSK, 8'hFF);
        settle_check();
        wr(OFS_PIN_CFG_LOW, 8'h0F);
        wr(OFS_PIN_CFG_HIGH, 8'h0F);
        wr(OFS_PIN_ALERT_MSK, 8'h00);
        settle_check();
        $display("test pins done");
        wr(OFS_EVT_OUT_CTRL, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            r = xs();
            wr(OFS_EVT_OUT1_MSK, {r[7:4], 4'(i)});
            wr(OFS_EVT_OUT2_MSK, {r[3:0], ~4'(i)});
            wr(OFS_PIN_CFG_LOW, xs());
            wr(OFS_PIN_CFG_HIGH, xs());
            r = xs();
            @(posedge MCLK);
            ext_low   <= xs();
            VOLT_EVT  <= r[0];
            THERMAL_LIMIT_EVENT_EVT <= r[1];
            FAN_EVT   <= r[2];
            settle_check();
        end
        $display("test events done");
        @(posedge MCLK);
        {VOLT_EVT, THERMAL_LIMIT_EVENT_EVT, FAN_EVT} <= 3'h0;
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_EVT_OUT1_MSK + 8'(k), 8'h7F);
            wr(OFS_EVT_OUT_CTRL, 8'h01 | (8'h02 << k));
            @(posedge MCLK);
            VOLT_EVT <= 1'b1;
            settle_check();
            @(posedge MCLK);
            VOLT_EVT <= 1'b0;
            settle_check();
            wr(OFS_EVT_OUT_CTRL, 8'h01 | (8'h0A << k));
            settle_check();
            rd(OFS_EVT_OUT_CTRL, "control");
        end
        $display("test latch done");
        reset_dut();
        wrap_up();
    end
endmodule : gpev_top_tb
